// *** rtl/pport_cfg_pkg.sv ***
// shared constants and carrier types for the resource configuration bank
package pport_cfg_pkg;

  // bus geometry
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam int CFG_W = 8;
  localparam int IRQ_LINES = 16;
  localparam int DMA_CHANS = 4;
  localparam int IO_ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [APB_ADDR_W-1:0] IDX_PP_BASE = 8'h09;
  localparam logic [APB_ADDR_W-1:0] IDX_PP_RES = 8'h0b;
  localparam logic [APB_ADDR_W-1:0] IDX_SA_ENABLE = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] IDX_SA_TEST = 8'h0d;

  // values after reset
  localparam logic [CFG_W-1:0] RST_PP_BASE = 8'h00;
  localparam logic [CFG_W-1:0] RST_PP_RES = 8'h40;
  localparam logic [CFG_W-1:0] RST_SA_ENABLE = 8'hf8;
  localparam logic [CFG_W-1:0] RST_SA_TEST = 8'hfe;

  // field positions
  localparam int PP_IRQ_LSB = 0;
  localparam int PP_DMA_LSB = 4;
  localparam int PP_POL_BIT = 7;
  localparam int SA_EN_BIT = 0;
  localparam int SA_APM_BIT = 1;
  localparam int SA_LEAK_BIT = 2;
  localparam int SA_TEST_BIT = 0;

  // reserved bits that always read as ones
  localparam logic [CFG_W-1:0] SA_ENABLE_RSVD = 8'hf8;
  localparam logic [CFG_W-1:0] SA_TEST_RSVD = 8'hfe;

  // base address arithmetic: base = 8 * select + offset
  localparam logic [IO_ADDR_W-1:0] PP_IO_OFFSET = 12'h100;
  localparam int PP_IO_SHIFT = 3;

  // interrupt codes that name a real line (3-7, 9-11, 14, 15)
  localparam logic [IRQ_LINES-1:0] IRQ_LEGAL_MASK = 16'hcef8;

  // decoded parallel port resources
  typedef struct packed {
    logic [IRQ_LINES-1:0] irqSel;  // one-hot line, zero if none
    logic [DMA_CHANS-1:0] dmaSel;  // one-hot channel, zero if none
    logic irqActiveHigh;           // polarity of the port interrupt
  } pp_res_t;

  // serial port control outputs
  typedef struct packed {
    logic mapped;       // port visible in the I/O map
    logic powerDown;    // port held in power down
    logic autoPm;       // automatic power management on
    logic outHiZ;       // output pins released
    logic inDisable;    // input pins gated off
    logic testMode;     // test mode enabled
  } sa_ctl_t;

endpackage

// *** rtl/irq_route_decode.sv ***
// decodes the interrupt and dma select codes into one-hot selects
`timescale 1ns/1ps
module irq_route_decode #(
  parameter int IRQ_LINES = pport_cfg_pkg::IRQ_LINES,
  parameter int DMA_CHANS = pport_cfg_pkg::DMA_CHANS
) (
  input wire logic [3:0] irqCode,           // 4-bit interrupt code
  input wire logic [2:0] dmaCode,           // 3-bit dma code
  output logic [IRQ_LINES-1:0] irqSel,      // one-hot line or zero
  output logic [DMA_CHANS-1:0] dmaSel       // one-hot channel or zero
);

  genvar i;

  // reserved and zero codes select no line at all
  generate
    for (i = 0; i < IRQ_LINES; i++) begin : g_irq
      assign irqSel[i] = (irqCode == 4'(i)) &&
                         pport_cfg_pkg::IRQ_LEGAL_MASK[i];
    end
  endgenerate

  // top code bit set means no channel
  generate
    for (i = 0; i < DMA_CHANS; i++) begin : g_dma
      assign dmaSel[i] = !dmaCode[2] && (dmaCode[1:0] == 2'(i));
    end
  endgenerate

endmodule // irq_route_decode

// *** rtl/pport_uart_resource_config.sv ***
// resource configuration bank for the parallel port and first serial port
// What this block does
// (RULE1) parallel port I/O base equals eight times select plus 0x100
// (RULE2) resource bits 3:0 choose interrupt line; reserved codes and zero none
// (RULE3) resource bits 6:4 choose dma 0-3; top bit set means none
// (RULE4) resource bit 7 sets interrupt polarity: 0 low, 1 high
// (RULE5) serial enable bit 0 clear unmaps port and holds power down
// (RULE6) serial enable bit 1 turns automatic power management on or off
// (RULE7) serial enable bit 2 releases outputs, gates inputs in power down
// (RULE8) serial mode bit 0 enables serial test mode
// (RULE9) reserved bits of both serial registers always read as ones
// (RULE10) no system interrupt line driven when none or reserved code
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module pport_uart_resource_config #(
  parameter int IRQ_LINES = pport_cfg_pkg::IRQ_LINES,
  parameter int DMA_CHANS = pport_cfg_pkg::DMA_CHANS
) (
  input wire logic clk,                              // 25 MHz clock
  input wire logic rst_n,                            // async reset
  input wire logic psel,                             // apb select
  input wire logic penable,                          // apb access phase
  input wire logic pwrite,                           // apb write
  input wire logic [pport_cfg_pkg::APB_ADDR_W-1:0] paddr,   // byte addr
  input wire logic [pport_cfg_pkg::APB_DATA_W-1:0] pwdata,  // write data
  output logic [pport_cfg_pkg::APB_DATA_W-1:0] prdata,      // read data
  output logic pready,                               // apb ready
  output logic pslverr,                              // unmapped access
  input wire logic ppIrqReq,                         // port wants service
  input wire logic saIdle,                           // serial port idle
  output logic [pport_cfg_pkg::IO_ADDR_W-1:0] ppBase,       // port base
  output pport_cfg_pkg::pp_res_t ppRes,              // decoded resources
  output logic [IRQ_LINES-1:0] sysIrqOut,            // irq line level
  output logic [IRQ_LINES-1:0] sysIrqOe_n,           // irq drive, low on
  output pport_cfg_pkg::sa_ctl_t saCtl               // serial controls
);

  localparam int AW = pport_cfg_pkg::APB_ADDR_W;
  localparam int DW = pport_cfg_pkg::APB_DATA_W;
  localparam int CW = pport_cfg_pkg::CFG_W;
  localparam int IW = pport_cfg_pkg::IO_ADDR_W;

  // stored configuration
  logic [CW-1:0] ppBaseSel;
  logic [CW-1:0] ppResSel;
  logic [2:0] saEnableBits;
  logic saTestBit;
  logic [CW-1:0] next_ppBaseSel;
  logic [CW-1:0] next_ppResSel;
  logic [2:0] next_saEnableBits;
  logic next_saTestBit;

  // bus answer state
  logic [DW-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // derived outputs
  logic [IW-1:0] next_ppBase;
  pport_cfg_pkg::pp_res_t next_ppRes;
  logic [IRQ_LINES-1:0] next_sysIrqOut;
  logic [IRQ_LINES-1:0] next_sysIrqOe_n;
  pport_cfg_pkg::sa_ctl_t next_saCtl;

  // decode helpers
  logic [AW-3:0] regIdx;
  logic wordAligned;
  logic hitPpBase;
  logic hitPpRes;
  logic hitSaEnable;
  logic hitSaTest;
  logic mapped;
  logic accessDone;
  logic doWrite;
  logic [CW-1:0] readByte;
  logic [IRQ_LINES-1:0] irqSel;
  logic [DMA_CHANS-1:0] dmaSel;
  logic saPowerDown;

  // address to register index; low two bits must be zero
  assign regIdx = paddr[AW-1:2];
  assign wordAligned = (paddr[1:0] == 2'b00);

  // register select by index
  always_comb begin
    hitPpBase = 1'b0;
    hitPpRes = 1'b0;
    hitSaEnable = 1'b0;
    hitSaTest = 1'b0;
    if (!wordAligned) begin
      hitPpBase = 1'b0;
    end else if (regIdx == pport_cfg_pkg::IDX_PP_BASE[AW-3:0]) begin
      hitPpBase = 1'b1;
    end else if (regIdx == pport_cfg_pkg::IDX_PP_RES[AW-3:0]) begin
      hitPpRes = 1'b1;
    end else if (regIdx == pport_cfg_pkg::IDX_SA_ENABLE[AW-3:0]) begin
      hitSaEnable = 1'b1;
    end else if (regIdx == pport_cfg_pkg::IDX_SA_TEST[AW-3:0]) begin
      hitSaTest = 1'b1;
    end
  end

  assign mapped = hitPpBase | hitPpRes | hitSaEnable | hitSaTest;
  // write lands only at the edge where the master sees pready
  assign accessDone = psel && penable && pready;
  assign doWrite = accessDone && pwrite && mapped;

  // read mux
  always_comb begin
    readByte = 8'h00;
    if (hitPpBase) begin
      readByte = ppBaseSel;
    end else if (hitPpRes) begin
      readByte = ppResSel;
    end else if (hitSaEnable) begin
      // (RULE9) reserved read ones
      readByte = pport_cfg_pkg::SA_ENABLE_RSVD | {5'h00, saEnableBits};
    end else if (hitSaTest) begin
      readByte = pport_cfg_pkg::SA_TEST_RSVD | {7'h00, saTestBit};
    end
  end

  // one wait state: answer is raised in the second access cycle
  always_comb begin
    next_pready = 1'b0;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      next_prdata = (!pwrite && mapped) ? {24'h0000_00, readByte} : '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // register writes; only the low byte carries configuration
  always_comb begin
    next_ppBaseSel = ppBaseSel;
    next_ppResSel = ppResSel;
    next_saEnableBits = saEnableBits;
    next_saTestBit = saTestBit;
    if (doWrite && hitPpBase) begin
      next_ppBaseSel = pwdata[CW-1:0];
    end
    if (doWrite && hitPpRes) begin
      next_ppResSel = pwdata[CW-1:0];
    end
    if (doWrite && hitSaEnable) begin
      next_saEnableBits = pwdata[2:0];
    end
    if (doWrite && hitSaTest) begin
      next_saTestBit = pwdata[pport_cfg_pkg::SA_TEST_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ppBaseSel <= pport_cfg_pkg::RST_PP_BASE;
      ppResSel <= pport_cfg_pkg::RST_PP_RES;
      saEnableBits <= pport_cfg_pkg::RST_SA_ENABLE[2:0];
      saTestBit <= pport_cfg_pkg::RST_SA_TEST[pport_cfg_pkg::SA_TEST_BIT];
    end else begin
      ppBaseSel <= next_ppBaseSel;
      ppResSel <= next_ppResSel;
      saEnableBits <= next_saEnableBits;
      saTestBit <= next_saTestBit;
    end
  end

  // (RULE2) interrupt code decode
  // (RULE3) dma code decode
  irq_route_decode #(
    .IRQ_LINES(IRQ_LINES),
    .DMA_CHANS(DMA_CHANS)
  ) u_decode (
    .irqCode(ppResSel[pport_cfg_pkg::PP_IRQ_LSB +: 4]),
    .dmaCode(ppResSel[pport_cfg_pkg::PP_DMA_LSB +: 3]),
    .irqSel(irqSel),
    .dmaSel(dmaSel)
  );

  // power down when disabled, or when idle under auto management
  assign saPowerDown = !saEnableBits[pport_cfg_pkg::SA_EN_BIT] ||
                       (saEnableBits[pport_cfg_pkg::SA_APM_BIT] && saIdle);

  // derived outputs, registered so every port comes from a flop
  always_comb begin
    // (RULE1) base address arithmetic
    next_ppBase = pport_cfg_pkg::PP_IO_OFFSET +
                  {ppBaseSel, 3'b000};
    next_ppRes.irqSel = irqSel;
    next_ppRes.dmaSel = dmaSel;
    // (RULE4) polarity select bit
    next_ppRes.irqActiveHigh = ppResSel[pport_cfg_pkg::PP_POL_BIT];
    // (RULE10) drive only the selected line
    next_sysIrqOe_n = ~irqSel;
    // (RULE4) asserted level follows polarity
    next_sysIrqOut = ppResSel[pport_cfg_pkg::PP_POL_BIT] ?
                     {IRQ_LINES{ppIrqReq}} : {IRQ_LINES{!ppIrqReq}};
    // (RULE5) enable maps the port
    next_saCtl.mapped = saEnableBits[pport_cfg_pkg::SA_EN_BIT];
    next_saCtl.powerDown = saPowerDown;
    // (RULE6) auto power management
    next_saCtl.autoPm = saEnableBits[pport_cfg_pkg::SA_APM_BIT];
    // (RULE7) pin leakage control
    next_saCtl.outHiZ = saPowerDown &&
                        saEnableBits[pport_cfg_pkg::SA_LEAK_BIT];
    next_saCtl.inDisable = saPowerDown &&
                           saEnableBits[pport_cfg_pkg::SA_LEAK_BIT];
    // (RULE8) test mode bit
    next_saCtl.testMode = saTestBit;
  end

  // outputs idle at reset: nothing driven, serial port powered down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ppBase <= pport_cfg_pkg::PP_IO_OFFSET;
      ppRes <= '0;
      sysIrqOut <= '0;
      sysIrqOe_n <= '1;
      saCtl <= 6'b010000;
    end else begin
      ppBase <= next_ppBase;
      ppRes <= next_ppRes;
      sysIrqOut <= next_sysIrqOut;
      sysIrqOe_n <= next_sysIrqOe_n;
      saCtl <= next_saCtl;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // base register write reaches the base output two edges later
  property p_base_follows;
    doWrite && hitPpBase |=> ##1
      ppBase == IW'(12'h100 + {$past(pwdata[CW-1:0], 2), 3'b000});
  endproperty
  a_base_follows: assert property (p_base_follows) // RULE1
    else $error("base address not eight times select plus offset");

  // reference decode of the stored code, kept apart from the decoder
  logic irqCodeLegal;
  assign irqCodeLegal = |(pport_cfg_pkg::IRQ_LEGAL_MASK &
                          (16'h0001 << ppResSel[3:0]));

  // reserved interrupt codes leave every line undriven
  property p_irq_none;
    !irqCodeLegal |=> sysIrqOe_n == '1;
  endproperty
  a_irq_none: assert property (p_irq_none) // RULE10
    else $error("interrupt line driven with no legal code");

  // legal code drives exactly the coded line
  property p_irq_line;
    irqCodeLegal |=> !sysIrqOe_n[$past(ppResSel[3:0])] &&
                           $countones(~sysIrqOe_n) == 1;
  endproperty
  a_irq_line: assert property (p_irq_line) // RULE2
    else $error("wrong interrupt line driven");

  // top dma bit leaves no channel
  property p_dma_none;
    ppResSel[6] |=> ppRes.dmaSel == '0;
  endproperty
  a_dma_none: assert property (p_dma_none) // RULE3
    else $error("dma channel selected with top bit set");

  // driven level on line 3 honours polarity
  property p_polarity;
    !sysIrqOe_n[3] |-> sysIrqOut[3] ==
      (ppRes.irqActiveHigh ? $past(ppIrqReq) : !$past(ppIrqReq));
  endproperty
  a_polarity: assert property (p_polarity) // RULE4
    else $error("interrupt level ignores polarity");

  // disabled serial port is unmapped and powered down
  property p_sa_disable;
    !saEnableBits[0] |=> !saCtl.mapped && saCtl.powerDown;
  endproperty
  a_sa_disable: assert property (p_sa_disable) // RULE5
    else $error("disabled serial port still active");

  // auto management off keeps an enabled port awake
  property p_sa_apm;
    saEnableBits[1:0] == 2'b01 |=> !saCtl.powerDown && !saCtl.autoPm;
  endproperty
  a_sa_apm: assert property (p_sa_apm) // RULE6
    else $error("power down without auto management");

  // pins released only in power down with leakage control set
  property p_sa_leak;
    saCtl.outHiZ |-> saCtl.powerDown && $past(saEnableBits[2]);
  endproperty
  a_sa_leak: assert property (p_sa_leak) // RULE7
    else $error("pins released outside leakage power down");

  // test mode output follows its bit
  property p_test_mode;
    ##1 saCtl.testMode == $past(saTestBit);
  endproperty
  a_test_mode: assert property (p_test_mode) // RULE8
    else $error("test mode output stale");

  // serial mode register reads reserved bits as ones
  property p_rsvd_ones;
    psel && penable && !pready && !pwrite && hitSaTest
      |=> pready && prdata[7:1] == 7'h7f;
  endproperty
  a_rsvd_ones: assert property (p_rsvd_ones) // RULE9
    else $error("reserved bits did not read as ones");

endmodule // pport_uart_resource_config

// *** rtl/pport_cfg_pkg_unused_guard.sv ***
// no logic here; the bank lives in the package and two design modules

// *** bench/pport_uart_resource_config_tb.sv ***
// self-checking bench for the resource configuration register bank
`timescale 1ns/1ps
module pport_uart_resource_config_tb;
  localparam int LIMIT = 20000;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ppIrqReq;
  logic saIdle;
  logic [11:0] ppBase;
  pport_cfg_pkg::pp_res_t ppRes;
  logic [15:0] sysIrqOut;
  logic [15:0] sysIrqOe_n;
  pport_cfg_pkg::sa_ctl_t saCtl;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  pport_uart_resource_config dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ppIrqReq(ppIrqReq),
    .saIdle(saIdle), .ppBase(ppBase), .ppRes(ppRes),
    .sysIrqOut(sysIrqOut), .sysIrqOe_n(sysIrqOe_n), .saCtl(saCtl)
  );

  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // derived outputs land one edge after the register
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  initial begin
    logic [3:0] c;
    logic [2:0] b;
    logic legal;
    logic [15:0] sel;
    logic [3:0] dsel;
    logic pd;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ppIrqReq = 1'b0;
    saIdle = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    // reset state of the outputs and registers
    chk("base_out", {20'h0, ppBase}, 32'h0000_0100);
    chk("res_out", {11'h0, ppRes}, 32'h0000_0000);
    chk("oe_rst", {16'h0, sysIrqOe_n}, 32'h0000_ffff);
    chk("sa_rst", {26'h0, saCtl}, 32'h0000_0010);
    apb(1'b0, 8'h24, 32'h0);
    chk("base_rst", rd, 32'h0000_0000);
    apb(1'b0, 8'h2c, 32'h0);
    chk("res_rst", rd, 32'h0000_0040);
    apb(1'b0, 8'h30, 32'h0);
    chk("en_rst", rd, 32'h0000_00f8);
    apb(1'b0, 8'h34, 32'h0);
    chk("test_rst", rd, 32'h0000_00fe);
    // unmapped and unaligned places refuse and leave registers alone
    apb(1'b1, 8'h28, 32'h0000_00ff);
    chk("unmap_err", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h25, 32'h0);
    chk("unalign_err", {31'h0, err}, 32'h0000_0001);
    chk("unalign_rd", rd, 32'h0000_0000);
    apb(1'b0, 8'h2c, 32'h0);
    chk("res_kept", rd, 32'h0000_0040);
    // base select boundaries; upper data bits are ignored
    apb(1'b1, 8'h24, 32'h1234_56ff);
    settle();
    chk("base_max", {20'h0, ppBase}, 32'h0000_08f8);
    apb(1'b1, 8'h24, 32'h0000_0081);
    settle();
    chk("base_mid", {20'h0, ppBase}, 32'h0000_0508);
    apb(1'b0, 8'h24, 32'h0);
    chk("base_rd", rd, 32'h0000_0081);
    // every interrupt code, dma code and both polarities
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      legal = !(c inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hc, 4'hd});
      sel = legal ? (16'h0001 << c) : 16'h0000;
      dsel = c[2] ? 4'h0 : (4'h1 << c[1:0]);
      ppIrqReq <= c[1];
      apb(1'b1, 8'h2c, {24'h0, c[0], c[2:0], c});
      settle();
      chk("irq_sel", {16'h0, ppRes.irqSel}, {16'h0, sel});
      chk("dma_sel", {28'h0, ppRes.dmaSel}, {28'h0, dsel});
      chk("pol", {31'h0, ppRes.irqActiveHigh}, {31'h0, c[0]});
      chk("irq_oe", {16'h0, sysIrqOe_n}, {16'h0, ~sel});
      if (legal) begin
        chk("irq_lvl", {31'h0, sysIrqOut[c]}, {31'h0, c[1] ~^ c[0]});
      end
      apb(1'b0, 8'h2c, 32'h0);
      chk("res_rd", rd, {24'h0, c[0], c[2:0], c});
    end
    // serial enable controls against both idle levels
    for (int i = 0; i < 16; i++) begin
      b = 3'(i);
      saIdle <= i[3];
      apb(1'b1, 8'h30, {29'h0, b});
      settle();
      pd = !b[0] || (b[1] && i[3]);
      chk("sa_map", {31'h0, saCtl.mapped}, {31'h0, b[0]});
      chk("sa_pd", {31'h0, saCtl.powerDown}, {31'h0, pd});
      chk("sa_apm", {31'h0, saCtl.autoPm}, {31'h0, b[1]});
      chk("sa_hiz", {31'h0, saCtl.outHiZ}, {31'h0, pd & b[2]});
      chk("sa_ind", {31'h0, saCtl.inDisable}, {31'h0, pd & b[2]});
      apb(1'b0, 8'h30, 32'h0);
      chk("en_rd", rd, {24'h0, 5'h1f, b});
    end
    // test mode on then off; reserved bits stay ones
    for (int i = 1; i >= 0; i--) begin
      apb(1'b1, 8'h34, 32'(i));
      settle();
      chk("test_mode", {31'h0, saCtl.testMode}, 32'(i));
      apb(1'b0, 8'h34, 32'h0);
      chk("test_rd", rd, 32'h0000_00fe | 32'(i));
    end
    // mid-run reset returns registers and outputs to reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk("base_out2", {20'h0, ppBase}, 32'h0000_0100);
    chk("sa_rst2", {26'h0, saCtl}, 32'h0000_0010);
    apb(1'b0, 8'h24, 32'h0);
    chk("base_rst2", rd, 32'h0000_0000);
    apb(1'b0, 8'h2c, 32'h0);
    chk("res_rst2", rd, 32'h0000_0040);
    apb(1'b0, 8'h30, 32'h0);
    chk("en_rst2", rd, 32'h0000_00f8);
    end_sim();
  end
endmodule // pport_uart_resource_config_tb
